// ---- core/csp_pkg.sv ----
/*
  Package for the core sequencing block: program counter, return stack,
  shadow context and the two indirect pointers.
  Assumes one instruction clock and a decoder that issues one-cycle
  command pulses to the core.
*/
// Function
// RULE1: return stack of 16 entries, 15 bits each, apart from data memory
// RULE2: overflow sets stack_overflow_flag, underflow sets stack_underflow_flag, status register
// RULE3: with stack error reset enabled, overflow or underflow forces software reset
// RULE4: two independent 16-bit indirect pointer registers
// RULE5: each pointer reaches all file registers and program memory
// RULE6: indirect access to program memory takes one extra instruction cycle
// RULE7: pointers give a linear view of general purpose RAM beyond 80 bytes
// RULE8: interrupt entry saves core registers to shadows; return restores them
// RULE9: program counter is 15 bits, 32K words of 14 bits
// RULE10: addresses above 3fff wrap into the implemented 16K words
// RULE11: reset starts at 0000, interrupt loads 0004
// RULE12: pointer high byte bit 7 selects program memory; read returns low byte
// RULE13: writes through the indirect port never modify program memory
// RULE14: calls and interrupts push return address; returns pop it
package csp_pkg;
  localparam int PC_W = 15;
  localparam int STK_DEPTH = 16;
  localparam int STK_PTR_W = 4;
  localparam int PTR_W = 16;
  localparam int IMPL_W = 14;
  localparam logic [14:0] IMPL_MASK = 15'h3fff;
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] INT_VEC = 15'h0004;
  localparam int PROG_SEL_BIT = 15;
  localparam int LIN_SEL_BIT = 13;
  localparam int GPR_PER_BANK = 80;
  localparam logic [11:0] GPR_BANK_BASE = 12'h020;
  localparam int BANK_SIZE = 128;
  localparam int POWER_CONTROL_STATUS_REG_OVF_BIT = 7;
  localparam int POWER_CONTROL_STATUS_REG_UNF_BIT = 6;
  typedef enum logic [2:0] {
    CSP_NOP, CSP_STEP, CSP_JUMP, CSP_CALL, CSP_RET, CSP_RETFIE, CSP_INT
  } csp_cmd_t;
endpackage

// ---- core/csp_stack_if.sv ----
/*
  Interface between the core top and its return stack.
  Assumes single clock; push and pop are one-cycle strobes.
*/
`timescale 1ns/10ps
`default_nettype none
interface csp_stack_if;
  logic push;
  logic pop;
  logic [14:0] push_data;
  logic [14:0] top_data;
  logic overflow;
  logic underflow;
  modport core (output push, output pop, output push_data,
                input top_data, input overflow, input underflow);
  modport stack (input push, input pop, input push_data,
                 output top_data, output overflow, output underflow);
endinterface
`default_nettype wire

// ---- core/csp_stack.sv ----
/*
  Hardware return stack of 16 entries.
  Assumes push and pop never both asserted; the core guarantees that.
*/
`timescale 1ns/10ps
`default_nettype none
module csp_stack
  import csp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core side
  csp_stack_if.stack sif
);
  // RULE1: dedicated storage
  logic [14:0] mem [STK_DEPTH];
  logic [STK_PTR_W:0] count;
  logic [STK_PTR_W:0] next_count;
  logic [STK_PTR_W-1:0] wr_idx;

  assign wr_idx = count[STK_PTR_W-1:0];
  assign sif.top_data = (count == '0) ? RESET_VEC : mem[wr_idx - 4'h1];

  // RULE2: detect overflow and underflow
  assign sif.overflow = sif.push && (count == 5'(STK_DEPTH));
  assign sif.underflow = sif.pop && (count == '0);

  always_comb begin
    next_count = count;
    if (sif.push && !sif.overflow) begin
      next_count = count + 5'h01;
    end else if (sif.pop && !sif.underflow) begin
      next_count = count - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // data cells are not reset, only the depth count matters
  always_ff @(posedge clk) begin
    if (sif.push && !sif.overflow) begin
      mem[wr_idx] <= sif.push_data;
    end
  end
endmodule
`default_nettype wire

// ---- core/csp_core.sv ----
/*
  Core sequencer: program counter, vectors, return stack control,
  shadow context, two indirect pointers and their address mapping.
  Assumes a decoder on the same clock issuing one command per cycle and
  waiting while stall is high; program memory answers in the same cycle as
  prog_rd_en.
*/
`timescale 1ns/10ps
`default_nettype none
module csp_core
  import csp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction stream
  input wire csp_cmd_t cmd,
  input wire logic [14:0] jump_addr,
  input wire logic stack_err_reset_en,
  // core registers to shadow
  input wire logic [7:0] work_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] bank_in,
  input wire logic [7:0] pclath_in,
  // pointer access
  input wire logic ptr_sel,
  input wire logic ptr_wr,
  input wire logic [15:0] ptr_wdata,
  input wire logic ind_rd,
  input wire logic ind_wr,
  input wire logic [7:0] ind_wdata,
  input wire logic [13:0] prog_rdata,
  // outputs
  output logic [14:0] pc,
  output logic stall,
  output logic [15:0] file_select_pointer0,
  output logic [15:0] file_select_pointer1,
  output logic [11:0] data_addr,
  output logic data_wr,
  output logic [7:0] data_wdata,
  output logic data_rd,
  output logic [14:0] prog_addr,
  output logic prog_rd_en,
  output logic [7:0] indirect_data_port,
  output logic ind_valid,
  output logic [7:0] power_control_status_reg,
  output logic soft_reset,
  output logic restore_valid,
  output logic [7:0] work_out,
  output logic [7:0] status_out,
  output logic [7:0] bank_out,
  output logic [7:0] pclath_out
);
  csp_stack_if sif ();
  csp_stack u_stack (
    .clk(clk),
    .rst(rst),
    .sif(sif)
  );

  logic [15:0] ptr [2];
  logic [15:0] next_ptr [2];
  logic [14:0] next_pc;
  logic next_stall;
  logic [7:0] next_power_control_status_reg;
  logic next_soft_reset;
  logic [31:0] shadow;
  logic [31:0] next_shadow;
  logic next_restore;
  logic [15:0] cur_ptr;
  logic [11:0] next_data_addr;
  logic next_data_wr;
  logic next_data_rd;
  logic next_prog_rd;
  logic [7:0] next_ind_data;
  logic next_ind_valid;
  logic [14:0] pc_inc;
  logic [14:0] lin_off;
  logic [6:0] lin_bank;
  logic [6:0] lin_byte;

  // RULE10: wrap above last implemented word
  assign pc_inc = (pc + 15'h0001) & IMPL_MASK;

  // ------------------------------------------------------------
  // program counter and stack
  // ------------------------------------------------------------
  always_comb begin
    next_pc = pc;
    sif.push = 1'b0;
    sif.pop = 1'b0;
    sif.push_data = pc_inc;
    next_power_control_status_reg = power_control_status_reg;
    next_soft_reset = 1'b0;
    next_shadow = shadow;
    next_restore = 1'b0;
    if (!stall) begin
      case (cmd)
        CSP_STEP: next_pc = pc_inc;
        CSP_JUMP: next_pc = jump_addr & IMPL_MASK;
        // RULE14: call pushes return address
        CSP_CALL: begin
          sif.push = 1'b1;
          next_pc = jump_addr & IMPL_MASK;
        end
        // RULE14: return pops address
        CSP_RET: begin
          sif.pop = 1'b1;
          next_pc = sif.top_data & IMPL_MASK;
        end
        // RULE8: restore shadows on return
        CSP_RETFIE: begin
          sif.pop = 1'b1;
          next_pc = sif.top_data & IMPL_MASK;
          next_restore = 1'b1;
        end
        // RULE11: interrupt vector, RULE8: save context
        CSP_INT: begin
          sif.push = 1'b1;
          sif.push_data = pc & IMPL_MASK;
          next_pc = INT_VEC;
          next_shadow = {work_in, status_in, bank_in, pclath_in};
        end
        default: next_pc = pc;
      endcase
    end
    // RULE2: sticky error flags, cleared only by reset
    if (sif.overflow) begin
      next_power_control_status_reg[POWER_CONTROL_STATUS_REG_OVF_BIT] = 1'b1;
    end
    if (sif.underflow) begin
      next_power_control_status_reg[POWER_CONTROL_STATUS_REG_UNF_BIT] = 1'b1;
    end
    // RULE3: optional software reset on stack error
    if ((sif.overflow || sif.underflow) && stack_err_reset_en) begin
      next_soft_reset = 1'b1;
      next_pc = RESET_VEC;
    end
  end

  // RULE9: 15-bit program counter
  always_ff @(posedge clk) begin
    if (rst) begin
      // RULE11: reset vector
      pc <= RESET_VEC;
      power_control_status_reg <= 8'h00;
      soft_reset <= 1'b0;
      shadow <= 32'h0000_0000;
      restore_valid <= 1'b0;
    end else begin
      pc <= next_pc;
      power_control_status_reg <= next_power_control_status_reg;
      soft_reset <= next_soft_reset;
      shadow <= next_shadow;
      restore_valid <= next_restore;
    end
  end

  assign work_out = shadow[31:24];
  assign status_out = shadow[23:16];
  assign bank_out = shadow[15:8];
  assign pclath_out = shadow[7:0];

  // ------------------------------------------------------------
  // indirect pointers
  // ------------------------------------------------------------
  assign cur_ptr = ptr[ptr_sel];
  assign file_select_pointer0 = ptr[0];
  assign file_select_pointer1 = ptr[1];
  // RULE7: linear gpr space, 80 bytes per bank
  assign lin_off = cur_ptr[12:0] + 15'h0000;
  assign lin_bank = 7'(lin_off / 15'(GPR_PER_BANK));
  assign lin_byte = 7'(lin_off % 15'(GPR_PER_BANK));

  // RULE4: two independent registers
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ptr
      always_comb begin
        next_ptr[i] = ptr[i];
        if (ptr_wr && (ptr_sel == 1'(i))) begin
          next_ptr[i] = ptr_wdata;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          ptr[i] <= 16'h0000;
        end else begin
          ptr[i] <= next_ptr[i];
        end
      end
    end
  endgenerate

  always_comb begin
    next_data_addr = cur_ptr[11:0];
    next_data_wr = 1'b0;
    next_data_rd = 1'b0;
    next_prog_rd = 1'b0;
    next_stall = 1'b0;
    next_ind_data = indirect_data_port;
    next_ind_valid = 1'b0;
    // RULE12: second cycle returns low byte of word
    if (stall) begin
      // a dropped write also stalls, but has no word to hand back
      if (prog_rd_en) begin
        next_ind_data = prog_rdata[7:0];
        next_ind_valid = 1'b1;
      end
    // RULE5: one pointer space for both memories
    end else if (cur_ptr[PROG_SEL_BIT]) begin
      if (ind_rd) begin
        // RULE6: one extra cycle for the fetch
        next_prog_rd = 1'b1;
        next_stall = 1'b1;
      end else if (ind_wr) begin
        // RULE13: write dropped, still costs the extra cycle
        next_stall = 1'b1;
      end
    end else begin
      if (cur_ptr[LIN_SEL_BIT]) begin
        next_data_addr = 12'({lin_bank, 5'h00} + {lin_bank, 7'h00} - {lin_bank, 5'h00})
                         + GPR_BANK_BASE + 12'(lin_byte);
      end
      next_data_wr = ind_wr;
      next_data_rd = ind_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_addr <= 12'h000;
      data_wr <= 1'b0;
      data_rd <= 1'b0;
      data_wdata <= 8'h00;
      prog_addr <= 15'h0000;
      prog_rd_en <= 1'b0;
      stall <= 1'b0;
      indirect_data_port <= 8'h00;
      ind_valid <= 1'b0;
    end else begin
      data_addr <= next_data_addr;
      data_wr <= next_data_wr;
      data_rd <= next_data_rd;
      data_wdata <= ind_wdata;
      // RULE10: program fetch also wraps
      prog_addr <= {1'b0, cur_ptr[IMPL_W-1:0]};
      prog_rd_en <= next_prog_rd;
      stall <= next_stall;
      indirect_data_port <= next_ind_data;
      ind_valid <= next_ind_valid;
    end
  end
endmodule
`default_nettype wire

// ---- sim/csp_monitor.sv ----
/*
  Port checker for the core sequencer.
  Assumes it is bound onto csp_core; one clock, synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module csp_monitor
  import csp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs watched
  input wire csp_cmd_t cmd,
  input wire logic [14:0] jump_addr,
  input wire logic stack_err_reset_en,
  input wire logic ptr_sel,
  input wire logic ind_rd,
  input wire logic ind_wr,
  // outputs watched
  input wire logic [14:0] pc,
  input wire logic stall,
  input wire logic [15:0] file_select_pointer0,
  input wire logic [15:0] file_select_pointer1,
  input wire logic data_wr,
  input wire logic ind_valid,
  input wire logic [7:0] power_control_status_reg,
  input wire logic soft_reset,
  input wire logic restore_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic prog_sel;
  assign prog_sel = ptr_sel ? file_select_pointer1[15] : file_select_pointer0[15];
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_jump;
    (cmd == CSP_JUMP || cmd == CSP_CALL) && !stall |=>
      soft_reset || pc == ($past(jump_addr) & IMPL_MASK);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");
  property p_vec;
    cmd == CSP_INT && !stall |=> soft_reset || pc == INT_VEC;
  endproperty
  a_vec: assert property (p_vec)
    else $error("interrupt vector wrong");
  property p_rst;
    $fell(rst) |-> pc == RESET_VEC;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset vector wrong");
  property p_stall;
    ind_rd && !stall && prog_sel |=> stall ##1 !stall;
  endproperty
  a_stall: assert property (p_stall)
    else $error("program access not one extra cycle");
  property p_rdval;
    ind_rd && !stall && prog_sel |-> ##2 ind_valid;
  endproperty
  a_rdval: assert property (p_rdval)
    else $error("program read result missing");
  property p_nowr;
    ind_wr && !stall && prog_sel |=> !data_wr [*2];
  endproperty
  a_nowr: assert property (p_nowr)
    else $error("program write leaked");
  property p_sticky;
    power_control_status_reg[7:6] != 2'b00 |=>
      (power_control_status_reg[7:6] & $past(power_control_status_reg[7:6])) ==
      $past(power_control_status_reg[7:6]);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("stack flag lost");
  property p_srst;
    soft_reset |-> $past(stack_err_reset_en) && power_control_status_reg[7:6] != 2'b00;
  endproperty
  a_srst: assert property (p_srst)
    else $error("soft reset without cause");
  property p_restore;
    cmd == CSP_RETFIE && !stall |-> ##[1:2] restore_valid;
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore not signalled");
endmodule
bind csp_core csp_monitor i_mon (.clk, .rst, .cmd, .jump_addr, .stack_err_reset_en,
  .ptr_sel, .ind_rd, .ind_wr, .pc, .stall, .file_select_pointer0, .file_select_pointer1,
  .data_wr, .ind_valid, .power_control_status_reg, .soft_reset, .restore_valid);
`default_nettype wire

// ---- sim/testbench.sv ----
/*
  Self-checking bench for the core sequencer.
  Assumes csp_core and its stack; inputs change on the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
  import csp_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, stack_err_reset_en = 1'b0;
  csp_cmd_t cmd = CSP_NOP;
  logic [14:0] jump_addr = 15'h0000, pc, prog_addr;
  logic [7:0] work_in = 8'h11, status_in = 8'h22, bank_in = 8'h33, pclath_in = 8'h44;
  logic ptr_sel = 1'b0, ptr_wr = 1'b0, ind_rd = 1'b0, ind_wr = 1'b0;
  logic [15:0] ptr_wdata = 16'h0000, file_select_pointer0, file_select_pointer1;
  logic [7:0] ind_wdata = 8'ha7, data_wdata, indirect_data_port, power_control_status_reg;
  logic [13:0] prog_rdata = 14'h2a5b;
  logic [11:0] data_addr;
  logic stall, data_wr, data_rd, ind_valid, soft_reset, seen, prog_rd_en, restore_valid;
  logic [7:0] work_out, status_out, bank_out, pclath_out;
  int fail_count = 0, checked = 0;
  csp_core i_dut (.clk, .rst, .cmd, .jump_addr, .stack_err_reset_en, .work_in, .status_in,
    .bank_in, .pclath_in, .ptr_sel, .ptr_wr, .ptr_wdata, .ind_rd, .ind_wr, .ind_wdata,
    .prog_rdata, .pc, .stall, .file_select_pointer0, .file_select_pointer1, .data_addr,
    .data_wr, .data_wdata, .data_rd, .prog_addr, .prog_rd_en, .indirect_data_port,
    .ind_valid, .power_control_status_reg, .soft_reset, .restore_valid, .work_out,
    .status_out, .bank_out, .pclath_out);
  always #12.5 clk = ~clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic op(input csp_cmd_t c, input logic [14:0] a);
    @(negedge clk);
    cmd = c;
    jump_addr = a;
    @(negedge clk);
    cmd = CSP_NOP;
  endtask
  task automatic ptr_load(input logic s, input logic [15:0] v);
    @(negedge clk);
    ptr_sel = s;
    ptr_wr = 1'b1;
    ptr_wdata = v;
    @(negedge clk);
    ptr_wr = 1'b0;
  endtask
  task automatic ind(input logic r, input logic w);
    @(negedge clk);
    ind_rd = r;
    ind_wr = w;
    @(negedge clk);
    ind_rd = 1'b0;
    ind_wr = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_flow;
    do_reset();
    chk(pc, 16'h0000);
    op(CSP_JUMP, 15'h3fff);
    op(CSP_STEP, 15'h0000);
    chk(pc, 16'h0000);
    op(CSP_JUMP, 15'h0100);
    chk(pc, 16'h0100);
    op(CSP_CALL, 15'h7123);
    chk(pc, 16'h3123);
    op(CSP_RET, 15'h0000);
    chk(pc, 16'h0101);
    op(CSP_INT, 15'h0000);
    chk(pc, 16'h0004);
    op(CSP_RETFIE, 15'h0000);
    chk(pc, 16'h0101);
    chk(restore_valid, 1'b1);
    chk({work_out, status_out}, 16'h1122);
    chk({bank_out, pclath_out}, 16'h3344);
  endtask
  task automatic t_stack;
    for (int i = 0; i < 16; i++) op(CSP_CALL, 15'(i * 16));
    chk(power_control_status_reg, 8'h00);
    op(CSP_CALL, 15'h0200);
    chk(power_control_status_reg, 8'h80);
    for (int i = 15; i >= 0; i--) begin
      op(CSP_RET, 15'h0000);
      chk(pc, (i == 0) ? 16'h0102 : 16'((i - 1) * 16 + 1));
    end
    stack_err_reset_en = 1'b1;
    seen = 1'b0;
    op(CSP_RET, 15'h0000);
    repeat (3) begin
      if (soft_reset === 1'b1) seen = 1'b1;
      @(negedge clk);
    end
    chk(seen, 1'b1);
    chk(pc, 16'h0000);
    chk(power_control_status_reg, 8'hc0);
  endtask
  task automatic t_ptr;
    do_reset();
    ptr_load(1'b0, 16'h8005);
    ind(1'b1, 1'b0);
    chk(stall, 1'b1);
    chk(prog_addr, 16'h0005);
    chk(prog_rd_en, 1'b1);
    @(negedge clk);
    chk(ind_valid, 1'b1);
    chk(indirect_data_port, 16'h005b);
    ind(1'b0, 1'b1);
    chk(data_wr, 1'b0);
    @(negedge clk);
    chk(ind_valid, 1'b0);
    ptr_load(1'b1, 16'h0123);
    ind(1'b0, 1'b1);
    chk({data_wr, data_addr}, 16'h1123);
    chk(data_wdata, 16'h00a7);
    chk(file_select_pointer0, 16'h8005);
    chk(file_select_pointer1, 16'h0123);
    ptr_load(1'b1, 16'h2055);
    ind(1'b1, 1'b0);
    chk({data_rd, data_addr}, 16'h10a5);
  endtask
  task automatic wrap_up;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_flow();
    t_stack();
    t_ptr();
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
